// file: design/host_port_pkg.sv
package host_port_pkg;

  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int IRQ_W  = 8;

  // Minimum low time of the reset pin and its cycle count at 100 MHz
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RST_MIN_NS      = 100;
  localparam int RST_MIN_CYCLES  =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W       = 8;

  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;

  // Pins from the external processor
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_in;
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic              ale;
  } host_pins_s;

  // Access toward the core register file
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              rd;
    logic              wr;
  } core_req_s;

endpackage

// file: design/octal_framer_host_port.sv
// Functional notes
// (R1) 11-bit address selects the target register
// (R2) 8-bit data bus, device drives on reads
// (R3) Read strobe low: addressed register onto bus
// (R4) Write strobe low: bus value written to register
// (R5) Host ties latch enable high when non-multiplexed
// (R6) Latch enable high passes; falling edge captures
// (R7) Chip select falls per access, held low throughout
// (R8) Chip select high once clears test modes
// (R9) Interrupt low until all unmasked sources acknowledged
// (R10) Reset pin low 100 ns resets whole device
module octal_framer_host_port #(
  parameter int RST_CYCLES = host_port_pkg::RST_MIN_CYCLES
) (
  input  wire logic                             mclk,
  input  wire logic                             rst,
  input  wire host_port_pkg::host_pins_s        pins,
  input  wire logic                             rst_pin_n,
  output logic [host_port_pkg::DATA_W-1:0]      data_out,
  output logic                                  data_oe,
  output logic                                  irq_n_out,
  output logic                                  irq_n_oe,
  output host_port_pkg::core_req_s              core_req,
  input  wire logic [host_port_pkg::DATA_W-1:0] core_rdata,
  input  wire logic [host_port_pkg::IRQ_W-1:0]  irq_pending,
  input  wire logic [host_port_pkg::IRQ_W-1:0]  irq_enable,
  output logic                                  test_mode_clr,
  output logic                                  device_reset
);
  import host_port_pkg::*;

  initial begin
    if (RST_CYCLES < 1 || RST_CYCLES >= (1 << RST_CNT_W)) begin
      $error("RST_CYCLES out of range");
    end
    // The strobe logic serves one byte lane and one address word only
    if (DATA_W != 8) begin
      $error("DATA_W must be 8");
    end
    if (ADDR_W != 11) begin
      $error("ADDR_W must be 11");
    end
  end

  logic [ADDR_W-1:0]    addr_hold_ff;
  logic                 ale_ff;
  logic                 cs_n_ff;
  logic                 rd_n_ff;
  logic                 wr_n_ff;
  logic                 cs_seen_high_ff;
  logic [RST_CNT_W-1:0] rst_cnt_ff;
  logic                 dev_rst_ff;
  logic [DATA_W-1:0]    rdata_ff;
  logic                 oe_ff;
  logic                 irq_ff;
  logic                 test_clr_ff;
  logic                 access_armed_ff;
  logic [ADDR_W-1:0]    eff_addr;
  logic                 sel;
  logic                 rd_fall;
  logic                 wr_rise;
  logic                 cs_fall;

  // Edge tests on registered pin levels, shared by all strobes
  function automatic logic fell(input logic prev, input logic now);
    return prev && ~now;
  endfunction

  function automatic logic rose(input logic prev, input logic now);
    return ~prev && now;
  endfunction

  // Latch enable high passes the pins; low selects the held word
  function automatic logic [ADDR_W-1:0] addr_pick(
    input logic              pass,
    input logic [ADDR_W-1:0] pin_addr,
    input logic [ADDR_W-1:0] held_addr
  );
    return pass ? pin_addr : held_addr;
  endfunction

  // Transparent while enable high, frozen from its falling edge on
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_hold_ff <= ADDR_RESET;
    end else if (pins.ale) begin
      addr_hold_ff <= pins.addr; // R6
    end
  end

  // Non-multiplexed hosts keep the enable high, so the pins pass directly
  assign eff_addr = addr_pick(pins.ale, pins.addr, addr_hold_ff); // R5 R6 R1

  // Previous pin levels; reset values match the idle pins so no
  // false edge appears right after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ale_ff  <= 1'b1;
      cs_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
    end else begin
      ale_ff  <= pins.ale;
      cs_n_ff <= pins.cs_n;
      rd_n_ff <= pins.rd_n;
      wr_n_ff <= pins.wr_n;
    end
  end

  // A strobe may fall in the same cycle as chip select
  assign sel     = ~pins.cs_n && (access_armed_ff || cs_fall); // R7
  assign cs_fall = fell(cs_n_ff, pins.cs_n);
  assign rd_fall = fell(rd_n_ff, pins.rd_n);
  // Write commits at strobe release so data has settled on the bus
  assign wr_rise = rose(wr_n_ff, pins.wr_n);

  // One access per chip-select low period; a second strobe is refused
  // so a bouncing strobe cannot repeat a read with side effects
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      access_armed_ff <= 1'b0;
    end else if (pins.cs_n) begin
      access_armed_ff <= 1'b0;
    end else if (sel && (rd_fall || wr_rise)) begin
      access_armed_ff <= 1'b0; // R7
    end else if (cs_fall) begin
      access_armed_ff <= 1'b1; // R7
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      core_req <= '0;
    end else begin
      core_req.addr  <= eff_addr; // R1
      core_req.wdata <= pins.data_in; // R2
      core_req.rd    <= sel && rd_fall; // R3
      core_req.wr    <= sel && wr_rise && ~cs_n_ff; // R4
    end
  end

  // Bus drive only for a clean read; never against a low write strobe,
  // where the host itself drives the data lines
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= ~pins.cs_n && ~pins.rd_n && pins.wr_n; // R2 R3
    end
  end

  // Read data is refreshed throughout the strobe low time, so a slow
  // host sees the latest register contents when it releases the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff <= DATA_RESET;
    end else if (~pins.cs_n && ~pins.rd_n) begin
      rdata_ff <= core_rdata; // R3
    end
  end

  assign data_out = rdata_ff;
  assign data_oe  = oe_ff;

  // Test modes stay set until the chip select has been seen high once
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_seen_high_ff <= 1'b0;
      test_clr_ff     <= 1'b0;
    end else begin
      test_clr_ff <= pins.cs_n && ~cs_seen_high_ff; // R8
      if (pins.cs_n) begin
        cs_seen_high_ff <= 1'b1;
      end
    end
  end

  assign test_mode_clr = test_clr_ff;

  // Level output: stays low while any enabled source remains pending
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_pending & irq_enable); // R9
    end
  end

  // Open drain: pull low only, never drive high
  assign irq_n_out = 1'b0;
  assign irq_n_oe  = irq_ff; // R9

  // Short glitches under the minimum width are filtered out; the
  // counter stops at the threshold and reset lasts until the pin rises
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rst_cnt_ff <= '0;
      dev_rst_ff <= 1'b1;
    end else if (rst_pin_n) begin
      rst_cnt_ff <= '0;
      dev_rst_ff <= 1'b0;
    end else if (rst_cnt_ff >= RST_CNT_W'(RST_CYCLES - 1)) begin
      dev_rst_ff <= 1'b1; // R10
    end else begin
      rst_cnt_ff <= rst_cnt_ff + 1'b1; // R10
    end
  end

  assign device_reset = dev_rst_ff;

  logic unused_ale;
  assign unused_ale = ale_ff;

endmodule // octal_framer_host_port

// file: sim/host_port_properties.sv
module host_port_properties
  import host_port_pkg::*;
#(parameter int RST_CYCLES = 10) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire host_pins_s        pins,
  input wire logic              rst_pin_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe,
  input wire logic              irq_n_oe,
  input wire core_req_s         core_req,
  input wire logic [DATA_W-1:0] core_rdata,
  input wire logic [IRQ_W-1:0]  irq_pending,
  input wire logic [IRQ_W-1:0]  irq_enable,
  input wire logic              test_mode_clr,
  input wire logic              device_reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] low_ff;
  logic       took_ff;
  // Saturates so a long reset pin stays counted
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_ff <= 8'h00;
    end else if (rst_pin_n) begin
      low_ff <= 8'h00;
    end else if (low_ff != 8'hFF) begin
      low_ff <= low_ff + 8'h01;
    end
  end
  // An access was already taken in this chip-select low period
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      took_ff <= 1'b0;
    end else begin
      took_ff <= (took_ff || core_req.rd || core_req.wr) && !pins.cs_n;
    end
  end
  sequence rd_start;
    !pins.cs_n && !pins.rd_n && $past(pins.rd_n) && !took_ff;
  endsequence
  sequence wr_end;
    $rose(pins.wr_n) && !pins.cs_n && !$past(pins.cs_n) && !took_ff;
  endsequence
  a_read_take: assert property (rd_start and pins.ale |=> core_req.rd &&
    core_req.addr == $past(pins.addr)) else $error("read not taken");
  a_read_drive: assert property (!pins.cs_n && !pins.rd_n |=> data_oe)
    else $error("bus not driven");
  a_read_data: assert property (data_oe |->
    data_out == $past(core_rdata)) else $error("read data wrong");
  a_bus_release: assert property (pins.rd_n || pins.cs_n |=> !data_oe)
    else $error("bus not released");
  a_write_take: assert property (wr_end |=> core_req.wr &&
    core_req.wdata == $past(pins.data_in)) else $error("write lost");
  a_irq_follow: assert property (1'b1 |=> irq_n_oe ==
    |($past(irq_pending) & $past(irq_enable))) else $error("irq wrong");
  a_pin_reset: assert property (int'(low_ff) >= RST_CYCLES |->
    device_reset) else $error("no device reset");
  a_test_clear: assert property (test_mode_clr |-> $past(pins.cs_n)
    ##1 !test_mode_clr) else $error("test clear pulse wrong");
  a_one_access: assert property (took_ff |->
    !core_req.rd && !core_req.wr) else $error("second access taken");
  a_addr_latch: assert property ($fell(pins.ale) |=>
    core_req.addr == $past(pins.addr, 2)) else $error("address not held");
endmodule // host_port_properties
bind octal_framer_host_port host_port_properties
  #(.RST_CYCLES(RST_CYCLES)) u_props (.*);

// file: sim/host_model.sv
module host_model
  import host_port_pkg::*;
(
  input  wire logic [DATA_W-1:0] dbus,
  input  wire logic              mclk,
  output host_pins_s             pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = {ADDR_RESET, 8'hFF, 4'hF};
  task automatic write(input logic [10:0] a, input logic [7:0] d);
    @(posedge mclk);
    pins.addr <= a;
    pins.data_in <= d;
    pins.cs_n <= 1'b0;
    pins.wr_n <= 1'b0;
    repeat (2) @(posedge mclk);
    pins.wr_n <= 1'b1;
    @(posedge mclk);
    pins.cs_n <= 1'b1;
    pins.data_in <= ~d;
  endtask
  task automatic read(input logic [10:0] a, output logic [7:0] d);
    @(posedge mclk);
    pins.addr <= a;
    pins.cs_n <= 1'b0;
    pins.rd_n <= 1'b0;
    repeat (3) @(posedge mclk);
    d = dbus;
    pins.rd_n <= 1'b1;
    pins.cs_n <= 1'b1;
  endtask
  // Multiplexed bus: address phase, then the lines carry other values
  task automatic read_mux(input logic [10:0] a, output logic [7:0] d);
    @(posedge mclk);
    pins.addr <= a;
    @(posedge mclk);
    pins.ale <= 1'b0;
    pins.addr <= ~a;
    pins.cs_n <= 1'b0;
    pins.rd_n <= 1'b0;
    repeat (3) @(posedge mclk);
    d = dbus;
    pins.rd_n <= 1'b1;
    pins.cs_n <= 1'b1;
    pins.ale <= 1'b1;
  endtask
  // Two read strobes inside one chip-select low period
  task automatic read_twice(input logic [10:0] a, output logic [7:0] d);
    @(posedge mclk);
    pins.addr <= a;
    pins.cs_n <= 1'b0;
    pins.rd_n <= 1'b0;
    repeat (3) @(posedge mclk);
    d = dbus;
    pins.rd_n <= 1'b1;
    @(posedge mclk);
    pins.rd_n <= 1'b0;
    repeat (2) @(posedge mclk);
    pins.rd_n <= 1'b1;
    pins.cs_n <= 1'b1;
  endtask
endmodule // host_model

// file: sim/octal_framer_host_port_bench.sv
module octal_framer_host_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import host_port_pkg::*;
  localparam int RC = 2;
  logic mclk = 0, rst = 1, rst_pin_n = 1, data_oe, irq_n_out, irq_n_oe;
  logic test_mode_clr, device_reset;
  logic [7:0] irq_pending = 0, irq_enable = 0, data_out, rdata, wd, v;
  logic [10:0] wa, tmc = 0;
  logic [10:0] a [3] = '{11'h000, 11'h7FF, 11'h2A5};
  host_pins_s hp, pw;
  core_req_s core_req;
  int n_mismatch = 0, compares = 0, cyc = 0, n_rd = 0;
  always #5 mclk = ~mclk;
  assign rdata = core_req.addr[7:0] ^ 8'h5A;
  always_comb begin
    pw = hp;
    if (data_oe) pw.data_in = data_out;
  end
  octal_framer_host_port #(.RST_CYCLES(RC)) dut (.mclk(mclk), .rst(rst),
    .pins(pw), .rst_pin_n(rst_pin_n), .data_out(data_out),
    .data_oe(data_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .core_req(core_req), .core_rdata(rdata), .irq_pending(irq_pending),
    .irq_enable(irq_enable), .test_mode_clr(test_mode_clr),
    .device_reset(device_reset));
  host_model host (.dbus(pw.data_in), .mclk(mclk), .pins(hp));
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (core_req.wr === 1'b1) {wa, wd} <= {core_req.addr, core_req.wdata};
    if (core_req.rd === 1'b1) n_rd <= n_rd + 1;
    if (test_mode_clr === 1'b1) tmc <= tmc + 11'h001;
    if (cyc == 3000) begin
      n_mismatch++;
      results;
    end
  end
  task chk(input logic [10:0] g, e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task t_bus;
    foreach (a[i]) begin
      host.write(a[i], ~a[i][7:0]);
      repeat (2) @(posedge mclk);
      chk(wa, a[i]);
      chk({3'h0, wd}, {3'h0, ~a[i][7:0]});
      host.read(a[i], v);
      chk({3'h0, v}, {3'h0, a[i][7:0] ^ 8'h5A});
    end
    $display("bus test done");
  endtask
  task t_mux;
    int k;
    host.read_mux(11'h3C6, v);
    repeat (2) @(posedge mclk);
    chk({3'h0, v}, {3'h0, 8'hC6 ^ 8'h5A});
    k = n_rd;
    host.read_twice(11'h155, v);
    repeat (2) @(posedge mclk);
    chk({3'h0, v}, {3'h0, 8'h55 ^ 8'h5A});
    chk(11'(n_rd - k), 11'h001);
    $display("mux test done");
  endtask
  task t_irq;
    {irq_pending, irq_enable} <= 16'h8101;
    repeat (3) @(posedge mclk);
    chk(irq_n_oe, 1);
    irq_enable <= 8'h7E;
    repeat (3) @(posedge mclk);
    chk({irq_n_oe, irq_n_out}, 0);
    $display("irq test done");
  endtask
  task t_rst;
    rst_pin_n <= 1'b0;
    @(posedge mclk);
    rst_pin_n <= 1'b1;
    @(negedge mclk);
    chk(device_reset, 0);
    repeat (2) @(posedge mclk);
    rst_pin_n <= 1'b0;
    repeat (RC) @(posedge mclk);
    @(negedge mclk);
    chk(device_reset, 1);
    @(posedge mclk);
    rst_pin_n <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(device_reset, 0);
    $display("reset test done");
  endtask
  task results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_bus;
    t_mux;
    t_irq;
    t_rst;
    chk(tmc, 1);
    results;
  end
endmodule // octal_framer_host_port_bench
